// ---- vga_palette_pkg.sv ----
// Purpose: shared constants for the legacy colour path and palette ports
// Assumes: byte accesses, 16-bit I/O style addresses
// Notes:   reset values not given by the hardware are plain choices
package vga_palette_pkg;
   localparam logic [15:0] ADDR_ATTR_WR   = 16'h03C0;
   localparam logic [15:0] ADDR_ATTR_RD   = 16'h03C1;
   localparam logic [15:0] ADDR_MASK      = 16'h03C6;
   localparam logic [15:0] ADDR_RD_PTR    = 16'h03C7;
   localparam logic [15:0] ADDR_WR_PTR    = 16'h03C8;
   localparam logic [15:0] ADDR_DATA_IO   = 16'h03C9;
   localparam logic [15:0] ADDR_DATA_MEM  = 16'h03C1;

   localparam int PIPE_COUNT  = 2;
   localparam int ENTRY_COUNT = 256;
   localparam int ATTR_COUNT  = 16;

   localparam logic [4:0] AIDX_MODE  = 5'h10;
   localparam logic [4:0] AIDX_PLANE = 5'h12;
   localparam logic [4:0] AIDX_PAN   = 5'h13;
   localparam logic [4:0] AIDX_CSEL  = 5'h14;

   localparam int MODE_P54_SEL    = 7;
   localparam int MODE_WIDE_PIXEL = 6;
   localparam int MODE_GRAPHICS   = 0;
   localparam int ARX_VIDEO_EN    = 5;

   localparam logic [1:0] STATE_WRITE_LAST = 2'h0;
   localparam logic [1:0] STATE_READ_LAST  = 2'h3;

   localparam logic [7:0] MASK_RESET = 8'hFF;
   localparam logic [7:0] ATTR_RESET = 8'h00;
   localparam logic [7:0] PTR_RESET  = 8'h00;
   localparam logic [3:0] PAN_LAST   = 4'h8;

   typedef enum logic [1:0] {RGB_RED, RGB_GREEN, RGB_BLUE} rgb_phase_t;
endpackage

// ---- vga_palette_lookup_access.sv ----
// Purpose: attribute colour controls, fine panning and the per-pipe
//          256 x 24-bit colour palettes with their byte ports
// Assumes: one register access per cycle, read and write never together
// Notes:   attribute data reads exist only on the I/O map, since the
//          memory map puts the palette data port at that address
`timescale 1ns/100ps
module vga_palette_lookup_access
(
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic [15:0]            regAddr,
   input  wire logic                   regWrite,
   input  wire logic                   regRead,
   input  wire logic [7:0]             regWrData,
   input  wire logic                   memMapped,
   input  wire logic                   accessPipe,
   input  wire logic                   attrFlipClear,
   output logic      [7:0]             regRdData,
   input  wire logic                   vgaMode,
   input  wire logic                   nineDot,
   input  wire logic                   pseudoNineDot,
   input  wire logic [3:0]             attrIn,
   input  wire logic [7:0]             widePixelIn,
   input  wire logic [1:0][7:0]        pipeIndexIn,
   output logic      [1:0][23:0]       pipeRgb,
   output logic      [3:0]             panShift,
   output logic      [3:0]             planeGate
);

   ////////////////////////////////////////////////////////////////////
   localparam logic [3:0] PAN_LAST_L = vga_palette_pkg::PAN_LAST;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] t);
      hit = (a == t);
   endfunction

   // undefined table cells give no shift
   function automatic logic [3:0] panCount(input logic [3:0] v,
                                           input logic gfx,
                                           input logic wide,
                                           input logic nine,
                                           input logic pseudo);
      panCount = 4'h0;
      if (wide)
      begin
         if (!v[0] && v < PAN_LAST_L)
            panCount = {1'b0, v[3:1]};
      end
      else if (!gfx && (nine || pseudo))
      begin
         if (v < PAN_LAST_L)
            panCount = (pseudo && v == 4'h7) ? 4'h7 : v + 4'h1;
      end
      else if (v < PAN_LAST_L)
         panCount = v;
   endfunction

   ////////////////////////////////////////////////////////////////////
   logic [5:0]  attrIdx_reg,   attrIdx_next;
   logic        attrFlip_reg,  attrFlip_next;
   logic [5:0]  attrPal_reg    [vga_palette_pkg::ATTR_COUNT];
   logic [5:0]  attrPal_next   [vga_palette_pkg::ATTR_COUNT];
   logic [7:0]  mode_reg,      mode_next;
   logic [5:0]  plane_reg,     plane_next;
   logic [3:0]  finePan_reg,   finePan_next;
   logic [3:0]  upperSel_reg,  upperSel_next;
   logic [7:0]  mask_reg,      mask_next;
   logic [7:0]  rdPtr_reg,     rdPtr_next;
   logic [7:0]  wrPtr_reg,     wrPtr_next;
   logic        lastRead_reg,  lastRead_next;
   logic [7:0]  red_reg,       red_next;
   logic [7:0]  green_reg,     green_next;
   logic [7:0]  rdData_reg,    rdData_next;
   logic [3:0]  pan_reg,       pan_next;
   logic        commit;
   logic        dataHit;
   logic [23:0] rdEntry;
   logic [3:0]  planeIdx;
   logic [5:0]  entry;
   logic [1:0]  p54;
   logic [7:0]  vgaIdx;
   logic [23:0] palette        [vga_palette_pkg::PIPE_COUNT]
                               [vga_palette_pkg::ENTRY_COUNT];
   vga_palette_pkg::rgb_phase_t phase_reg, phase_next;

   assign dataHit = memMapped
                    ? hit(regAddr, vga_palette_pkg::ADDR_DATA_MEM)
                    : hit(regAddr, vga_palette_pkg::ADDR_DATA_IO);
   assign rdEntry = palette[accessPipe][rdPtr_reg];
   assign regRdData = rdData_reg;
   assign panShift  = pan_reg;
   assign planeGate = plane_reg[3:0];

   ////////////////////////////////////////////////////////////////////
   // attribute controller side: index/data flip-flop at the write port
   always_comb
   begin
      attrIdx_next  = attrIdx_reg;
      attrFlip_next = attrFlip_reg;
      attrPal_next  = attrPal_reg;
      mode_next     = mode_reg;
      plane_next    = plane_reg;
      finePan_next  = finePan_reg;
      upperSel_next = upperSel_reg;
      if (regWrite && hit(regAddr, vga_palette_pkg::ADDR_ATTR_WR))
      begin
         attrFlip_next = !attrFlip_reg;
         if (!attrFlip_reg)
            attrIdx_next = regWrData[5:0];
         else
         begin
            // entries locked while video is enabled
            if (!attrIdx_reg[4] && !attrIdx_reg[vga_palette_pkg::ARX_VIDEO_EN])
               attrPal_next[attrIdx_reg[3:0]] = regWrData[5:0];
            case (attrIdx_reg[4:0])
               vga_palette_pkg::AIDX_MODE:  mode_next = regWrData & 8'hEF;
               vga_palette_pkg::AIDX_PLANE: plane_next = regWrData[5:0];
               vga_palette_pkg::AIDX_PAN:   finePan_next = regWrData[3:0];
               vga_palette_pkg::AIDX_CSEL:  upperSel_next = regWrData[3:0];
               default:                     mode_next = mode_reg;
            endcase
         end
      end
      if (attrFlipClear)
         attrFlip_next = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         attrIdx_reg  <= 6'h00;
         attrFlip_reg <= 1'b0;
         mode_reg     <= vga_palette_pkg::ATTR_RESET;
         plane_reg    <= 6'h00;
         finePan_reg  <= 4'h0;
         upperSel_reg <= 4'h0;
         for (int i = 0; i < vga_palette_pkg::ATTR_COUNT; i++)
            attrPal_reg[i] <= 6'h00;
      end
      else
      begin
         attrIdx_reg  <= attrIdx_next;
         attrFlip_reg <= attrFlip_next;
         attrPal_reg  <= attrPal_next;
         mode_reg     <= mode_next;
         plane_reg    <= plane_next;
         finePan_reg  <= finePan_next;
         upperSel_reg <= upperSel_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // palette ports; one shared byte phase serves reads and writes
   always_comb
   begin
      mask_next     = mask_reg;
      rdPtr_next    = rdPtr_reg;
      wrPtr_next    = wrPtr_reg;
      lastRead_next = lastRead_reg;
      red_next      = red_reg;
      green_next    = green_reg;
      phase_next    = phase_reg;
      rdData_next   = rdData_reg;
      pan_next      = panCount(finePan_reg,
                               mode_reg[vga_palette_pkg::MODE_GRAPHICS],
                               mode_reg[vga_palette_pkg::MODE_WIDE_PIXEL],
                               nineDot, pseudoNineDot);
      commit        = 1'b0;
      if (regWrite)
      begin
         if (dataHit)
         begin
            case (phase_reg)
               vga_palette_pkg::RGB_RED:
               begin
                  red_next   = regWrData;
                  phase_next = vga_palette_pkg::RGB_GREEN;
               end
               vga_palette_pkg::RGB_GREEN:
               begin
                  green_next = regWrData;
                  phase_next = vga_palette_pkg::RGB_BLUE;
               end
               default:
               begin
                  commit     = 1'b1;
                  wrPtr_next = wrPtr_reg + 8'h01;
                  phase_next = vga_palette_pkg::RGB_RED;
               end
            endcase
         end
         else if (hit(regAddr, vga_palette_pkg::ADDR_MASK))
            mask_next = regWrData;
         else if (hit(regAddr, vga_palette_pkg::ADDR_RD_PTR))
         begin
            rdPtr_next    = regWrData;
            lastRead_next = 1'b1;
            phase_next    = vga_palette_pkg::RGB_RED;
         end
         else if (hit(regAddr, vga_palette_pkg::ADDR_WR_PTR))
         begin
            wrPtr_next    = regWrData;
            lastRead_next = 1'b0;
            phase_next    = vga_palette_pkg::RGB_RED;
         end
      end
      else if (regRead)
      begin
         rdData_next = 8'h00;
         if (dataHit)
         begin
            case (phase_reg)
               vga_palette_pkg::RGB_RED:
               begin
                  rdData_next = rdEntry[23:16];
                  phase_next  = vga_palette_pkg::RGB_GREEN;
               end
               vga_palette_pkg::RGB_GREEN:
               begin
                  rdData_next = rdEntry[15:8];
                  phase_next  = vga_palette_pkg::RGB_BLUE;
               end
               default:
               begin
                  rdData_next = rdEntry[7:0];
                  rdPtr_next  = rdPtr_reg + 8'h01;
                  phase_next  = vga_palette_pkg::RGB_RED;
               end
            endcase
         end
         else if (hit(regAddr, vga_palette_pkg::ADDR_MASK))
            rdData_next = mask_reg;
         else if (hit(regAddr, vga_palette_pkg::ADDR_RD_PTR))
            rdData_next = {6'h00, lastRead_reg ? vga_palette_pkg::STATE_READ_LAST
                                               : vga_palette_pkg::STATE_WRITE_LAST};
         else if (hit(regAddr, vga_palette_pkg::ADDR_ATTR_WR))
            rdData_next = {2'h0, attrIdx_reg};
         else if (hit(regAddr, vga_palette_pkg::ADDR_ATTR_RD))
         begin
            case (attrIdx_reg[4:0])
               vga_palette_pkg::AIDX_MODE:  rdData_next = mode_reg;
               vga_palette_pkg::AIDX_PLANE: rdData_next = {2'h0, plane_reg};
               vga_palette_pkg::AIDX_PAN:   rdData_next = {4'h0, finePan_reg};
               vga_palette_pkg::AIDX_CSEL:  rdData_next = {4'h0, upperSel_reg};
               default:
                  rdData_next = attrIdx_reg[4] ? 8'h00
                                : {2'h0, attrPal_reg[attrIdx_reg[3:0]]};
            endcase
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mask_reg     <= vga_palette_pkg::MASK_RESET;
         rdPtr_reg    <= vga_palette_pkg::PTR_RESET;
         wrPtr_reg    <= vga_palette_pkg::PTR_RESET;
         lastRead_reg <= 1'b0;
         red_reg      <= 8'h00;
         green_reg    <= 8'h00;
         phase_reg    <= vga_palette_pkg::RGB_RED;
         rdData_reg   <= 8'h00;
         pan_reg      <= 4'h0;
      end
      else
      begin
         mask_reg     <= mask_next;
         rdPtr_reg    <= rdPtr_next;
         wrPtr_reg    <= wrPtr_next;
         lastRead_reg <= lastRead_next;
         red_reg      <= red_next;
         green_reg    <= green_next;
         phase_reg    <= phase_next;
         rdData_reg   <= rdData_next;
         pan_reg      <= pan_next;
      end
   end

   // array holds no reset: contents are undefined until loaded
   always_ff @(posedge clk)
   begin
      if (commit)
         palette[accessPipe][wrPtr_reg] <= {red_reg, green_reg, regWrData};
   end

   ////////////////////////////////////////////////////////////////////
   // colour index build for the legacy pixel stream
   always_comb
   begin
      planeIdx = attrIn & plane_reg[3:0];
      entry    = attrPal_reg[planeIdx];
      p54      = mode_reg[vga_palette_pkg::MODE_P54_SEL] ? upperSel_reg[1:0]
                                                        : entry[5:4];
      vgaIdx   = {upperSel_reg[3:2], p54, entry[3:0]};
      if (mode_reg[vga_palette_pkg::MODE_WIDE_PIXEL])
         vgaIdx = widePixelIn;
      if (!attrIdx_reg[vga_palette_pkg::ARX_VIDEO_EN])
         vgaIdx = 8'h00;
   end

   // pipe 0 carries the legacy stream while it is in use
   for (genvar p = 0; p < vga_palette_pkg::PIPE_COUNT; p++)
   begin : g_pipe
      logic [7:0]  lookIdx;
      logic [23:0] rgb_reg, rgb_next;
      always_comb
      begin
         lookIdx  = ((p == 0) && vgaMode) ? vgaIdx : pipeIndexIn[p];
         lookIdx  = lookIdx & mask_reg;
         rgb_next = palette[p][lookIdx];
      end
      always_ff @(posedge clk)
      begin
         if (reset)
            rgb_reg <= 24'h000000;
         else
            rgb_reg <= rgb_next;
      end
      assign pipeRgb[p] = rgb_reg;
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_early_wr;
      regWrite && dataHit && phase_reg != vga_palette_pkg::RGB_BLUE;
   endsequence
   sequence s_third_wr;
      regWrite && dataHit && phase_reg == vga_palette_pkg::RGB_BLUE;
   endsequence
   sequence s_third_rd;
      regRead && !regWrite && dataHit
         && phase_reg == vga_palette_pkg::RGB_BLUE;
   endsequence

   a_read_advance: assert property (s_third_rd |=>
      rdPtr_reg == 8'($past(rdPtr_reg) + 8'h01)
      && phase_reg == vga_palette_pkg::RGB_RED)
      else $error("read pointer not advanced");
   a_write_hold: assert property (s_early_wr |=>
      wrPtr_reg == $past(wrPtr_reg))
      else $error("write pointer moved early");
   a_write_three: assert property (s_third_wr |=>
      phase_reg == vga_palette_pkg::RGB_RED
      && wrPtr_reg == 8'($past(wrPtr_reg) + 8'h01))
      else $error("write sequence not closed");
   a_rdptr_abort: assert property (regWrite
      && hit(regAddr, vga_palette_pkg::ADDR_RD_PTR)
      |=> phase_reg == vga_palette_pkg::RGB_RED && lastRead_reg && !commit)
      else $error("read pointer write did not restart");
   a_wrptr_state: assert property (regWrite
      && hit(regAddr, vga_palette_pkg::ADDR_WR_PTR)
      |=> !lastRead_reg && phase_reg == vga_palette_pkg::RGB_RED
      && wrPtr_reg == $past(regWrData))
      else $error("write pointer write wrong");
   a_pan_nine: assert property (!mode_reg[0] && !mode_reg[6]
      && nineDot && !pseudoNineDot && finePan_reg < 4'h8
      ##1 $stable(finePan_reg) |-> pan_reg == finePan_reg + 4'h1)
      else $error("nine-dot pan wrong");
   a_pan_eight: assert property (mode_reg[0] && !mode_reg[6]
      && finePan_reg < 4'h8
      ##1 $stable(finePan_reg) && $stable(mode_reg)
      |-> pan_reg == finePan_reg)
      else $error("eight-dot pan wrong");
   a_pan_wide: assert property (mode_reg[6] |=> pan_reg <= 4'h4)
      else $error("256-colour pan too large");
   a_p54_alt: assert property (mode_reg[7] && !mode_reg[6]
      && attrIdx_reg[5]
      |-> vgaIdx[5:4] == upperSel_reg[1:0]
      && vgaIdx[7:6] == upperSel_reg[3:2])
      else $error("upper index bits wrong");
   a_mask_and: assert property (
      (g_pipe[1].lookIdx & ~mask_reg) == 8'h00)
      else $error("mask not applied");
endmodule

// ---- vga_palette_lookup_access_tb.sv ----
// Purpose: self-checking bench for the palette ports and colour controls
// Assumes: one register access at a time, launched on a rising edge
// Notes:   palette array is not reset, so every entry read was written first
`timescale 1ns/100ps
module vga_palette_lookup_access_tb;
   logic              clk = 1'b0;
   logic              reset = 1'b1;
   logic [15:0]       regAddr = 16'h0000;
   logic              regWrite = 1'b0;
   logic              regRead = 1'b0;
   logic [7:0]        regWrData = 8'h00;
   logic              memMapped = 1'b0;
   logic              accessPipe = 1'b0;
   logic              attrFlipClear = 1'b0;
   logic [7:0]        regRdData;
   logic              vgaMode = 1'b0;
   logic              nineDot = 1'b0;
   logic              pseudoNineDot = 1'b0;
   logic [3:0]        attrIn = 4'h0;
   logic [7:0]        widePixelIn = 8'h00;
   logic [1:0][7:0]   pipeIndexIn = 16'h0000;
   logic [1:0][23:0]  pipeRgb;
   logic [3:0]        panShift;
   logic [3:0]        planeGate;
   int                fails = 0;
   int                tests_run = 0;

   always #5 clk = ~clk;

   vga_palette_lookup_access uut
   (
      .clk           (clk),
      .reset         (reset),
      .regAddr       (regAddr),
      .regWrite      (regWrite),
      .regRead       (regRead),
      .regWrData     (regWrData),
      .memMapped     (memMapped),
      .accessPipe    (accessPipe),
      .attrFlipClear (attrFlipClear),
      .regRdData     (regRdData),
      .vgaMode       (vgaMode),
      .nineDot       (nineDot),
      .pseudoNineDot (pseudoNineDot),
      .attrIn        (attrIn),
      .widePixelIn   (widePixelIn),
      .pipeIndexIn   (pipeIndexIn),
      .pipeRgb       (pipeRgb),
      .panShift      (panShift),
      .planeGate     (planeGate)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string what, input logic [23:0] exp,
                        input logic [23:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr   <= a;
      regWrData <= d;
      regWrite  <= 1'b1;
      @(posedge clk);
      regWrite  <= 1'b0;
   endtask

   // answer is registered at the taking edge, so sample just after it
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask

   task automatic rdc(input logic [15:0] a, input logic [7:0] e,
                      input string what);
      logic [7:0] b;
      rd(a, b);
      check(what, {16'h0000, e}, {16'h0000, b});
   endtask

   function automatic logic [15:0] dp();
      return memMapped ? vga_palette_pkg::ADDR_DATA_MEM
                       : vga_palette_pkg::ADDR_DATA_IO;
   endfunction

   function automatic logic [23:0] pat(input logic [7:0] s);
      return {s, s ^ 8'h5A, ~s};
   endfunction

   task automatic fill(input logic [7:0] idx, input int n,
                       input logic [7:0] s);
      logic [23:0] v;
      wr(vga_palette_pkg::ADDR_WR_PTR, idx);
      rdc(vga_palette_pkg::ADDR_RD_PTR, 8'h00, "state");
      for (int k = 0; k < n; k++)
      begin
         v = pat(s + 8'(k));
         for (int j = 2; j >= 0; j--)
            wr(dp(), v[j*8 +: 8]);
      end
   endtask

   task automatic verify(input logic [7:0] idx, input int n,
                         input logic [7:0] s);
      logic [23:0] got;
      wr(vga_palette_pkg::ADDR_RD_PTR, idx);
      rdc(vga_palette_pkg::ADDR_RD_PTR, 8'h03, "state");
      for (int k = 0; k < n; k++)
      begin
         for (int j = 2; j >= 0; j--)
            rd(dp(), got[j*8 +: 8]);
         check("entry", pat(s + 8'(k)), got);
      end
   endtask

   // index byte keeps video enable set unless an entry is addressed
   task automatic aw(input logic [7:0] idx, input logic [7:0] val);
      wr(vga_palette_pkg::ADDR_ATTR_WR, idx);
      wr(vga_palette_pkg::ADDR_ATTR_WR, val);
   endtask

   function automatic logic [3:0] panExp(input int m, input int v);
      case (m)
         0: return (v == 8) ? 4'h0 : 4'(v + 1);
         1: return (v == 8) ? 4'h0 : (v == 7) ? 4'h7 : 4'(v + 1);
         4: return 4'(v / 2);
         default: return 4'(v);
      endcase
   endfunction

   initial
   begin
      repeat (100000) @(posedge clk);
      fails++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [23:0] v;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rdc(vga_palette_pkg::ADDR_RD_PTR, 8'h00, "reset state");
      rdc(vga_palette_pkg::ADDR_WR_PTR, 8'h00, "wr ptr read");
      rdc(16'h03C2, 8'h00, "unmapped");
      wr(vga_palette_pkg::ADDR_MASK, 8'h5A);
      rdc(vga_palette_pkg::ADDR_MASK, 8'h5A, "mask");
      // no pointer written yet: the entry lands at the reset index
      v = pat(8'h33);
      for (int j = 2; j >= 0; j--)
         wr(dp(), v[j*8 +: 8]);
      verify(8'h00, 1, 8'h33);
      // whole palette from index zero, 768 bytes each way
      fill(8'h00, 256, 8'h00);
      verify(8'h00, 256, 8'h00);
      // three entries across the top, pointers must wrap
      fill(8'hFE, 3, 8'h10);
      verify(8'hFE, 3, 8'h10);
      // partial write dropped by a read pointer write
      fill(8'h14, 1, 8'hA0);
      wr(vga_palette_pkg::ADDR_WR_PTR, 8'h14);
      wr(dp(), 8'hB1);
      wr(dp(), 8'hB2);
      verify(8'h14, 1, 8'hA0);
      v = pat(8'hC0);
      for (int j = 2; j >= 0; j--)
         wr(dp(), v[j*8 +: 8]);
      verify(8'h14, 1, 8'hC0);
      wr(vga_palette_pkg::ADDR_RD_PTR, 8'h14);
      rdc(dp(), 8'hC0, "first byte");
      verify(8'h14, 1, 8'hC0);
      @(posedge clk);
      accessPipe <= 1'b1;
      fill(8'h14, 1, 8'hD0);
      verify(8'h14, 1, 8'hD0);
      @(posedge clk);
      accessPipe <= 1'b0;
      verify(8'h14, 1, 8'hC0);
      wr(vga_palette_pkg::ADDR_MASK, 8'h14);
      pipeIndexIn <= {8'h3C, 8'h3C};
      repeat (2) @(posedge clk);
      #1 check("pipe0 rgb", pat(8'hC0), pipeRgb[0]);
      check("pipe1 rgb", pat(8'hD0), pipeRgb[1]);
      wr(vga_palette_pkg::ADDR_MASK, 8'hFF);
      @(posedge clk);
      memMapped <= 1'b1;
      fill(8'h40, 1, 8'hE0);
      @(posedge clk);
      memMapped <= 1'b0;
      verify(8'h40, 1, 8'hE0);
      // panning table for each character width and colour depth
      @(posedge clk);
      attrFlipClear <= 1'b1;
      @(posedge clk);
      attrFlipClear <= 1'b0;
      for (int m = 0; m < 5; m++)
      begin
         @(posedge clk);
         nineDot       <= (m < 2);
         pseudoNineDot <= (m == 1);
         aw(8'h30, (m == 4) ? 8'h41 : (m == 3) ? 8'h01 : 8'h00);
         for (int v = 0; v < 9; v++)
         begin
            if ((m > 1 && v == 8) || (m == 4 && v % 2 == 1))
               continue;
            aw(8'h33, 8'(v));
            repeat (2) @(posedge clk);
            #1 check("pan", {20'h0, panExp(m, v)}, {20'h0, panShift});
         end
      end
      // legacy attribute path into pipe 0
      @(posedge clk);
      vgaMode <= 1'b1;
      attrIn  <= 4'h5;
      fill(8'hDA, 1, 8'h61);
      fill(8'hEA, 1, 8'h71);
      aw(8'h05, 8'h2A);
      aw(8'h34, 8'h0D);
      aw(8'h32, 8'h0F);
      #1 check("plane gate", 24'h00000F, {20'h0, planeGate});
      wr(vga_palette_pkg::ADDR_ATTR_WR, 8'h34);
      rdc(vga_palette_pkg::ADDR_ATTR_RD, 8'h0D, "colour select");
      @(posedge clk);
      attrFlipClear <= 1'b1;
      @(posedge clk);
      attrFlipClear <= 1'b0;
      aw(8'h30, 8'h00);
      repeat (4) @(posedge clk);
      #1 check("entry bits", pat(8'h71), pipeRgb[0]);
      aw(8'h30, 8'h80);
      repeat (4) @(posedge clk);
      #1 check("alternate bits", pat(8'h61), pipeRgb[0]);
      // 256-colour pixels bypass the attribute entries
      @(posedge clk);
      widePixelIn <= 8'hEA;
      aw(8'h30, 8'h41);
      repeat (4) @(posedge clk);
      #1 check("wide pixel", pat(8'h71), pipeRgb[0]);
      conclude();
   end
endmodule
